// *** stm_pkg.sv ***
// Package: register map, field positions, reset values and mode codes of the standard timer
package stm_pkg;
    localparam logic [2:0] STM_ADDR_CTRL0 = 3'h0;
    localparam logic [2:0] STM_ADDR_CTRL1 = 3'h1;
    localparam logic [2:0] STM_ADDR_CNT_LO = 3'h2;
    localparam logic [2:0] STM_ADDR_CNT_HI = 3'h3;
    localparam logic [2:0] STM_ADDR_DUTY_LO = 3'h4;
    localparam logic [2:0] STM_ADDR_DUTY_HI = 3'h5;
    localparam logic [2:0] STM_ADDR_FLAGS = 3'h6;
    localparam logic [7:0] STM_RESET_BYTE = 8'h00;
    localparam int STM_CNT_W = 10;
    localparam int STM_PER_W = 3;
    localparam int STM_PER_LSB = 7;
    localparam int STM_BIT_PAUSE = 7;
    localparam int STM_BIT_RUN = 3;
    localparam int STM_BIT_MODE_HI = 7;
    localparam int STM_BIT_MODE_LO = 6;
    localparam int STM_BIT_FUNC_HI = 5;
    localparam int STM_BIT_FUNC_LO = 4;
    localparam int STM_BIT_LEVEL = 3;
    localparam int STM_BIT_INV = 2;
    localparam int STM_BIT_SWAP = 1;
    localparam int STM_BIT_CLRSEL = 0;
    localparam int STM_BIT_DUTY_FLAG = 0;
    localparam int STM_BIT_PER_FLAG = 1;
    localparam logic [7:0] STM_PRESCALE_DEFAULT = 8'h04;
    typedef enum logic [1:0] {
        STM_MODE_COMPARE = 2'h0,
        STM_MODE_CAPTURE = 2'h1,
        STM_MODE_PWM = 2'h2,
        STM_MODE_TIMER = 2'h3
    } stm_mode_t;
    typedef enum logic [1:0] {
        STM_FN_A = 2'h0,
        STM_FN_B = 2'h1,
        STM_FN_C = 2'h2,
        STM_FN_D = 2'h3
    } stm_func_t;
endpackage

// *** stm_tick_div.sv ***
// Timer clock enable divider: one-cycle tick every DIV reference clocks
module stm_tick_div
    import stm_pkg::*;
#(
    parameter int DIV_W = 8
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [DIV_W-1:0] div,
    output logic tick
);
    typedef struct packed {
        logic [DIV_W-1:0] cnt;
        logic tick;
    } stm_div_state_t;
    stm_div_state_t s_q, s_d;
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        // A divide of zero behaves as one, so the timer never stalls
        if (s_q.cnt + DIV_W'(1) >= div) begin
            s_d.cnt = '0;
            s_d.tick = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + DIV_W'(1);
        end
    end
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end
    assign tick = s_q.tick;
endmodule

// *** stm_timer.sv ***
// Standard 10-bit timer: counter, comparators, output pin and byte register port
module stm_timer
    import stm_pkg::*;
#(
    parameter int CNT_W = STM_CNT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    output logic timer_output_pin,
    output logic duty_match_irq,
    output logic period_match_irq
);
    typedef struct packed {
        logic [7:0] ctrl0;
        logic [7:0] ctrl1;
        logic [7:0] prescale;
        logic [CNT_W-1:0] count;
        logic [CNT_W-1:0] duty_compare_value;
        logic [7:0] low_buf;
        logic run_prev;
        logic pin;
        logic duty_match_flag;
        logic period_match_flag;
        logic [7:0] rdata;
    } stm_state_t;

    stm_state_t s_q, s_d;
    logic tick;

    stm_tick_div #(.DIV_W(8)) u_div (
        .ref_clk(ref_clk),
        .rst(rst),
        .div(s_q.prescale),
        .tick(tick)
    );

    stm_mode_t mode;
    stm_func_t pin_func;
    logic timer_run, timer_pause, output_level_ctrl, output_invert, duty_period_swap, clear_source_sel;
    logic [STM_PER_W-1:0] period_field_bits;
    logic period_hit, duty_hit, overflow, clr, single_pulse, pwm_period_hit;
    logic pwm_active, pin_raw;

    always_comb begin
        mode = stm_mode_t'(s_q.ctrl1[STM_BIT_MODE_HI:STM_BIT_MODE_LO]);
        pin_func = stm_func_t'(s_q.ctrl1[STM_BIT_FUNC_HI:STM_BIT_FUNC_LO]);
        output_level_ctrl = s_q.ctrl1[STM_BIT_LEVEL];
        output_invert = s_q.ctrl1[STM_BIT_INV];
        duty_period_swap = s_q.ctrl1[STM_BIT_SWAP];
        clear_source_sel = s_q.ctrl1[STM_BIT_CLRSEL];
        timer_run = s_q.ctrl0[STM_BIT_RUN];
        timer_pause = s_q.ctrl0[STM_BIT_PAUSE];
        period_field_bits = s_q.ctrl0[STM_PER_W-1:0];
        single_pulse = (mode == STM_MODE_PWM) && (pin_func == STM_FN_D);
    end

    // Match events only when the counter is about to step, one per timer clock
    always_comb begin
        overflow = (s_q.count == {CNT_W{1'b1}});
        // Matching on the next count gives exactly n*128 clocks per period
        period_hit = (period_field_bits != '0)
            && ((s_q.count + CNT_W'(1)) == {period_field_bits, {STM_PER_LSB{1'b0}}});
        duty_hit = (s_q.duty_compare_value != '0)
            && ((s_q.count + CNT_W'(1)) == s_q.duty_compare_value);
        pwm_period_hit = duty_period_swap ? duty_hit : (period_hit || (period_field_bits == '0 && overflow));
        // Duty against counter: period field times 128 when swapped, else full value
        if (duty_period_swap) begin
            pwm_active = (period_field_bits == '0)
                || (s_q.count < {period_field_bits, {STM_PER_LSB{1'b0}}});
        end else begin
            pwm_active = (s_q.count < s_q.duty_compare_value);
        end
        if (mode == STM_MODE_PWM && !single_pulse) begin
            clr = pwm_period_hit;
        end else if (single_pulse) begin
            clr = 1'b0;
        end else if (clear_source_sel) begin
            clr = duty_hit || overflow;
        end else begin
            clr = period_hit || overflow;
        end
    end

    always_comb begin
        s_d = s_q;
        s_d.rdata = 8'h00;
        s_d.run_prev = timer_run;
        // Write one to clear, taken before the events so a new match wins
        if (reg_wr && reg_addr == STM_ADDR_FLAGS) begin
            if (reg_wdata[STM_BIT_DUTY_FLAG]) begin
                s_d.duty_match_flag = 1'b0;
            end
            if (reg_wdata[STM_BIT_PER_FLAG]) begin
                s_d.period_match_flag = 1'b0;
            end
        end
        // Counter
        if (timer_run && !s_q.run_prev) begin
            s_d.count = '0;
            if (mode == STM_MODE_COMPARE) begin
                s_d.pin = output_level_ctrl;
            end else if (single_pulse) begin
                s_d.pin = 1'b1;
            end
        end else if (timer_run && !timer_pause && tick) begin
            s_d.count = clr ? '0 : s_q.count + CNT_W'(1);
            unique case (mode)
                STM_MODE_COMPARE, STM_MODE_TIMER: begin
                    if (duty_hit) begin
                        s_d.duty_match_flag = 1'b1;
                    end
                    if (period_hit && !clear_source_sel) begin
                        s_d.period_match_flag = 1'b1;
                    end
                    if (mode == STM_MODE_COMPARE && duty_hit) begin
                        unique case (pin_func)
                            STM_FN_A: s_d.pin = s_q.pin;
                            STM_FN_B: s_d.pin = 1'b0;
                            STM_FN_C: s_d.pin = 1'b1;
                            STM_FN_D: s_d.pin = !s_q.pin;
                        endcase
                    end
                end
                STM_MODE_PWM: begin
                    if (duty_hit) begin
                        s_d.duty_match_flag = 1'b1;
                    end
                    if (period_hit && !single_pulse) begin
                        s_d.period_match_flag = 1'b1;
                    end
                    // Single pulse ends on duty match, which also stops the timer
                    if (single_pulse && duty_hit) begin
                        s_d.pin = 1'b0;
                        s_d.ctrl0[STM_BIT_RUN] = 1'b0;
                    end
                end
                STM_MODE_CAPTURE: begin
                    if (period_hit) begin
                        s_d.period_match_flag = 1'b1;
                    end
                end
            endcase
        end
        if (single_pulse && !timer_run) begin
            s_d.pin = 1'b0;
        end
        // Register writes; software writes cannot clear a flag set this cycle
        if (reg_wr) begin
            unique case (reg_addr)
                STM_ADDR_CTRL0: s_d.ctrl0 = reg_wdata;
                STM_ADDR_CTRL1: s_d.ctrl1 = reg_wdata;
                STM_ADDR_DUTY_LO: s_d.low_buf = reg_wdata;
                STM_ADDR_DUTY_HI: s_d.duty_compare_value = {reg_wdata[1:0], s_q.low_buf};
                STM_ADDR_FLAGS, STM_ADDR_CNT_LO, STM_ADDR_CNT_HI: ;
                default: s_d.prescale = reg_wdata;
            endcase
        end
        if (reg_rd) begin
            unique case (reg_addr)
                STM_ADDR_CTRL0: s_d.rdata = s_q.ctrl0;
                STM_ADDR_CTRL1: s_d.rdata = s_q.ctrl1;
                STM_ADDR_CNT_LO, STM_ADDR_DUTY_LO: s_d.rdata = s_q.low_buf;
                STM_ADDR_CNT_HI: begin
                    s_d.rdata = {6'h00, s_q.count[9:8]};
                    s_d.low_buf = s_q.count[7:0];
                end
                STM_ADDR_DUTY_HI: begin
                    s_d.rdata = {6'h00, s_q.duty_compare_value[9:8]};
                    s_d.low_buf = s_q.duty_compare_value[7:0];
                end
                STM_ADDR_FLAGS: s_d.rdata = {6'h00, s_q.period_match_flag, s_q.duty_match_flag};
                default: s_d.rdata = s_q.prescale;
            endcase
        end
    end

    // Output level before inversion
    always_comb begin
        unique case (mode)
            STM_MODE_PWM: begin
                unique case (pin_func)
                    STM_FN_A: pin_raw = !output_level_ctrl;
                    STM_FN_B: pin_raw = output_level_ctrl;
                    STM_FN_C: pin_raw = (pwm_active && timer_run) ? output_level_ctrl : !output_level_ctrl;
                    STM_FN_D: pin_raw = s_q.pin ? output_level_ctrl : !output_level_ctrl;
                endcase
            end
            STM_MODE_COMPARE: pin_raw = s_q.pin;
            // Pin unused in timer and capture modes; held low
            default: pin_raw = 1'b0;
        endcase
    end

    logic pin_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            s_q <= '0;
            s_q.prescale <= STM_PRESCALE_DEFAULT;
            pin_q <= 1'b0;
        end else begin
            s_q <= s_d;
            pin_q <= (mode == STM_MODE_TIMER || mode == STM_MODE_CAPTURE) ? 1'b0 : (pin_raw ^ output_invert);
        end
    end

    assign reg_rdata = s_q.rdata;
    assign timer_output_pin = pin_q;
    assign duty_match_irq = s_q.duty_match_flag;
    assign period_match_irq = s_q.period_match_flag;
endmodule

// *** stm_timer_monitor.sv ***
// Checker: port-level assertions for the standard timer
module stm_timer_mon
    import stm_pkg::*;
#(
    parameter int CNT_W = STM_CNT_W
) (
    input wire logic ref_clk,
    input wire logic rst,
    input wire logic [2:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic timer_output_pin,
    input wire logic duty_match_irq,
    input wire logic period_match_irq
);
    // Shadow of the mode register, rebuilt from bus writes only
    logic [7:0] c1_q;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            c1_q <= 8'h00;
        end else if (reg_wr && reg_addr == STM_ADDR_CTRL1) begin
            c1_q <= reg_wdata;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_reset_clears_out: assert property ($past(rst) |-> !timer_output_pin && !duty_match_irq
        && !period_match_irq && reg_rdata == 8'h00) else $error("outputs not clear after reset");
    a_rdata_idle_zero: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data not zero outside a read");
    a_high_byte_zero: assert property ($past(reg_rd) && ($past(reg_addr) == STM_ADDR_CNT_HI
        || $past(reg_addr) == STM_ADDR_DUTY_HI) |-> reg_rdata[7:2] == 6'h00) else $error("high byte upper bits set");
    a_ctrl_readback: assert property (reg_wr && reg_addr == STM_ADDR_CTRL1 ##1 reg_rd
        && reg_addr == STM_ADDR_CTRL1 |=> reg_rdata == $past(reg_wdata, 2)) else $error("mode register readback");
    a_duty_commit_hi: assert property (reg_wr && reg_addr == STM_ADDR_DUTY_LO ##1 reg_wr
        && reg_addr == STM_ADDR_DUTY_HI ##1 reg_rd && reg_addr == STM_ADDR_DUTY_HI
        |=> reg_rdata == ($past(reg_wdata, 2) & 8'h03)) else $error("duty high byte not committed");
    a_duty_flag_sticky: assert property (duty_match_irq && !(reg_wr && reg_addr == STM_ADDR_FLAGS
        && reg_wdata[STM_BIT_DUTY_FLAG]) |=> duty_match_irq) else $error("duty flag dropped");
    a_per_flag_sticky: assert property (period_match_irq && !(reg_wr && reg_addr == STM_ADDR_FLAGS
        && reg_wdata[STM_BIT_PER_FLAG]) |=> period_match_irq) else $error("period flag dropped");
    a_flags_read_back: assert property ($past(reg_rd) && $past(reg_addr) == STM_ADDR_FLAGS
        |-> reg_rdata[1:0] == {$past(period_match_irq), $past(duty_match_irq)}) else $error("flag read");
    a_no_period_flag: assert property (c1_q[7:6] == 2'h0 && c1_q[STM_BIT_CLRSEL]
        |-> !$rose(period_match_irq)) else $error("period flag with duty clear");
    a_timer_pin_low: assert property ((c1_q[7:6] == 2'h3) [*3] |-> !timer_output_pin)
        else $error("pin driven in timer mode");
    c_both_flags: cover property (duty_match_irq && period_match_irq);
    c_pin_rise: cover property ($rose(timer_output_pin));
    c_count_read: cover property (reg_rd && reg_addr == STM_ADDR_CNT_HI);
endmodule

bind stm_timer stm_timer_mon #(.CNT_W(CNT_W)) u_mon (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .timer_output_pin(timer_output_pin), .duty_match_irq(duty_match_irq), .period_match_irq(period_match_irq));

// *** stm_timer_tb.sv ***
// Testbench: register-level tests of the standard timer
module testbench
    import stm_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic [2:0] reg_addr = 3'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_rdata;
    logic timer_output_pin;
    logic duty_match_irq;
    logic period_match_irq;
    int n_errors = 0;
    int comparisons = 0;
    always #12.5 ref_clk = ~ref_clk;
    stm_timer #(.CNT_W(STM_CNT_W)) dut (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer_output_pin(timer_output_pin),
        .duty_match_irq(duty_match_irq), .period_match_irq(period_match_irq));
    task automatic conclude();
        $display("counts: %0d comparisons, %0d mismatches", comparisons, n_errors);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Range compare; an unknown value never falls inside
    task automatic cmp(input logic [7:0] got, input logic [7:0] lo, input logic [7:0] hi);
        comparisons++;
        if ($isunknown(got) || got < lo || got > hi) begin
            n_errors++;
            $display("mismatch at %0t: got %h, want %h..%h", $time, got, lo, hi);
        end
    endtask
    // Strobes stay up between ops so back-to-back access is possible
    task automatic wr(input logic [2:0] a, input logic [7:0] v);
        reg_wr <= 1'b1;
        reg_rd <= 1'b0;
        reg_addr <= a;
        reg_wdata <= v;
        @(posedge ref_clk);
    endtask
    task automatic rdc(input logic [2:0] a, input logic [7:0] lo, input logic [7:0] hi);
        reg_rd <= 1'b1;
        reg_wr <= 1'b0;
        reg_addr <= a;
        @(posedge ref_clk);
        fork
            #1 cmp(reg_rdata, lo, hi);
        join_none
    endtask
    task automatic idle(input int n);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge ref_clk);
    endtask
    // Pin looked at once settled after the edge
    task automatic pin_is(input logic e);
        fork
            #1 cmp({7'h00, timer_output_pin}, {7'h00, e}, {7'h00, e});
        join_none
    endtask
    // Flag sampled 1 ns after each edge; returns on an edge
    task automatic wfl(input logic per, input int lo, input int hi);
        int n;
        n = 0;
        #1;
        while (n <= hi && (per ? period_match_irq : duty_match_irq) !== 1'b1) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        cmp(8'(n), 8'(lo), 8'(hi));
        @(posedge ref_clk);
    endtask
    task automatic done(input string s);
        $display("test %s done", s);
    endtask
    initial begin
        logic [7:0] c;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        @(posedge ref_clk);
        for (int i = 0; i < 7; i++) rdc(3'(i), 8'h00, 8'h00);
        rdc(3'h7, STM_PRESCALE_DEFAULT, STM_PRESCALE_DEFAULT);
        wr(STM_ADDR_DUTY_LO, 8'h5A);
        wr(STM_ADDR_DUTY_HI, 8'hFF);
        rdc(STM_ADDR_DUTY_HI, 8'h03, 8'h03);
        rdc(STM_ADDR_DUTY_LO, 8'h5A, 8'h5A);
        wr(STM_ADDR_CTRL1, 8'hA5);
        rdc(STM_ADDR_CTRL1, 8'hA5, 8'hA5);
        done("registers");
        // One timer clock per reference clock keeps the run short
        wr(3'h7, 8'h01);
        wr(STM_ADDR_DUTY_LO, 8'h40);
        wr(STM_ADDR_DUTY_HI, 8'h00);
        wr(STM_ADDR_CTRL1, 8'h30);
        wr(STM_ADDR_CTRL0, 8'h09);
        idle(1);
        wfl(1'b0, 58, 70);
        pin_is(1'b1);
        wfl(1'b1, 55, 72);
        pin_is(1'b1);
        wr(STM_ADDR_CTRL0, 8'h01);
        rdc(STM_ADDR_FLAGS, 8'h03, 8'h03);
        wr(STM_ADDR_FLAGS, 8'h03);
        rdc(STM_ADDR_FLAGS, 8'h00, 8'h00);
        done("compare");
        wr(STM_ADDR_CTRL1, 8'h31);
        wr(STM_ADDR_DUTY_LO, 8'hC0);
        wr(STM_ADDR_DUTY_HI, 8'h00);
        wr(STM_ADDR_CTRL0, 8'h09);
        idle(3);
        pin_is(1'b0);
        wfl(1'b0, 183, 196);
        idle(300);
        cmp({7'h00, period_match_irq}, 8'h00, 8'h00);
        done("clear select");
        wr(STM_ADDR_CTRL0, 8'h00);
        wr(STM_ADDR_FLAGS, 8'h03);
        // Timer mode: duty zero is kept out of compare mode
        wr(STM_ADDR_CTRL1, 8'hC0);
        wr(STM_ADDR_DUTY_LO, 8'h00);
        wr(STM_ADDR_DUTY_HI, 8'h00);
        wr(STM_ADDR_CTRL0, 8'h08);
        idle(1100);
        cmp({7'h00, duty_match_irq}, 8'h00, 8'h00);
        rdc(STM_ADDR_CNT_HI, 8'h00, 8'h00);
        rdc(STM_ADDR_CNT_LO, 8'd68, 8'd84);
        done("overflow");
        wr(STM_ADDR_DUTY_LO, 8'h20);
        wr(STM_ADDR_DUTY_HI, 8'h00);
        for (int k = 0; k < 12; k++) begin
            c = {(k < 4) ? 2'h0 : 2'h2, 1'b0, k >= 8, k[0], k[1], 2'h0};
            wr(STM_ADDR_CTRL0, 8'h00);
            wr(STM_ADDR_CTRL1, c);
            wr(STM_ADDR_CTRL0, 8'h08);
            idle(4);
            pin_is(((k >= 4 && k < 8) ? !k[0] : k[0]) ^ k[1]);
        end
        wr(STM_ADDR_CTRL0, 8'h00);
        wr(STM_ADDR_CTRL1, 8'hCC);
        wr(STM_ADDR_CTRL0, 8'h08);
        idle(4);
        pin_is(1'b0);
        wr(STM_ADDR_CTRL0, 8'h00);
        wr(STM_ADDR_DUTY_LO, 8'h20);
        wr(STM_ADDR_DUTY_HI, 8'h00);
        wr(STM_ADDR_CTRL1, 8'h28);
        wr(STM_ADDR_CTRL0, 8'h08);
        idle(1);
        wfl(1'b0, 25, 40);
        pin_is(1'b1);
        done("pin levels");
        wr(STM_ADDR_CTRL0, 8'h00);
        wr(STM_ADDR_CTRL1, 8'hC0);
        wr(STM_ADDR_CTRL0, 8'h08);
        wr(STM_ADDR_CTRL0, 8'h88);
        idle(50);
        rdc(STM_ADDR_CNT_HI, 8'h00, 8'h00);
        rdc(STM_ADDR_CNT_LO, 8'h00, 8'h03);
        wr(STM_ADDR_CTRL0, 8'h08);
        idle(20);
        rdc(STM_ADDR_CNT_HI, 8'h00, 8'h00);
        rdc(STM_ADDR_CNT_LO, 8'd18, 8'd30);
        wr(STM_ADDR_CTRL0, 8'h00);
        wr(STM_ADDR_CNT_LO, 8'hFF);
        wr(STM_ADDR_CNT_HI, 8'hFF);
        idle(20);
        rdc(STM_ADDR_CNT_HI, 8'h00, 8'h00);
        rdc(STM_ADDR_CNT_LO, 8'd20, 8'd34);
        idle(2);
        done("pause and stop");
        conclude();
    end
    initial begin
        #250000;
        n_errors++;
        $display("mismatch at %0t: watchdog expired", $time);
        conclude();
    end
endmodule
